// ### design/acp_consts.vh
// acp_consts.vh: addresses, field positions, reset values and timing figures
// of the accelerometer power and mode control bank.
// assumes a 200 MHz ref_clk and an 8-bit register port.
`ifndef ACP_CONSTS_VH
`define ACP_CONSTS_VH

// clock rate
`define ACP_CLK_MHZ          200

// register addresses
`define ACP_ADDR_PWR         8'h3f
`define ACP_ADDR_CHECK       8'h40
`define ACP_ADDR_SRST        8'h41
`define ACP_ADDR_TIMING      8'h42
`define ACP_ADDR_STATUS      8'h43
`define ACP_ADDR_MASK        8'h44

// reset values
`define ACP_PWR_RST          8'h00
`define ACP_CHECK_RST        8'h00
`define ACP_TIMING_RST       8'h00
`define ACP_IRQ_RST          3'h0
`define ACP_ZERO8            8'h00

// power control fields; bit 6 is reserved and reads as zero
`define ACP_PWR_WMASK        8'hbf
`define ACP_PWR_FAST         7
`define ACP_PWR_IMPACT       5
`define ACP_PWR_SETTLE       4
`define ACP_PWR_LPF          3
`define ACP_PWR_HPF          2
`define ACP_PWR_MODE_HI      1
`define ACP_PWR_MODE_LO      0

// operating modes
`define ACP_MODE_STANDBY     2'h0
`define ACP_MODE_WAKE        2'h1
`define ACP_MODE_INSTANT     2'h2
`define ACP_MODE_FULL        2'h3

// diagnostic check fields
`define ACP_CHECK_START      0
`define ACP_CHECK_DONE       1

// timing register fields
`define ACP_TIM_CLK          0
`define ACP_TIM_TRIG         1

// interrupt status and mask bits
`define ACP_IRQ_SETTLED      0
`define ACP_IRQ_CHECKED      1
`define ACP_IRQ_SAMPLE       2
`define ACP_IRQ_W            3

// soft reset key
`define ACP_SRST_KEY         8'h52

// timing figures in their own units
`define ACP_SETTLE_US        462500
`define ACP_ODR_HZ           2560
`define ACP_CHECK_US         100
`define ACP_SETTLE_ODR_N     27'h0000004
`define ACP_TMR_W            27
`define ACP_ONE27            27'h0000001
`define ACP_ZERO27           27'h0000000

`endif

// ### design/acp_timer.v
// acp_timer.v: a loadable down counter that reports a one-cycle pulse when
// the loaded count of steps has elapsed.
// assumes one clock; clr is synchronous and wins over load.
`timescale 1ns/1ps
`include "acp_consts.vh"

module acp_timer #(
   parameter W = `ACP_TMR_W
) (
   input  wire         ref_clk,
   input  wire         clr,
   input  wire         load,
   input  wire [W-1:0] load_val,
   input  wire         step,
   output reg          busy_r,
   output reg          done_r
);

   reg [W-1:0] cnt_r;

   // count steps while busy; a load restarts the wait from scratch
   always @(posedge ref_clk) begin
      if (clr) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         cnt_r  <= {W{1'b0}};
      end else begin
         done_r <= 1'b0;
         if (load) begin
            busy_r <= 1'b1;
            cnt_r  <= load_val;
         end else if (busy_r && step) begin
            if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule

// ### design/acp_ctrl.v
// acp_ctrl.v: power, mode, filter, diagnostic check, soft reset and sample
// timing control of a three-axis accelerometer, with a small interrupt block.
// assumes a host on the same ref_clk driving one-cycle read/write strobes;
// the two irq pins come from the board and are synchronised here.
`timescale 1ns/1ps
`include "acp_consts.vh"

module acp_ctrl #(
   parameter [26:0] SETTLE_CYC = `ACP_SETTLE_US * `ACP_CLK_MHZ,
   parameter [26:0] ODR_CYC    = (`ACP_CLK_MHZ * 1000000) / `ACP_ODR_HZ,
   parameter [26:0] CHECK_CYC  = `ACP_CHECK_US * `ACP_CLK_MHZ
) (
   input  wire       ref_clk,
   input  wire       rst_b,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   output reg  [1:0] mode_r,
   output reg        fast_bus_speed_select_r,
   output reg        impact_wake_level_select_r,
   output reg        settling_period_select_r,
   output reg        lowpass_bypass_r,
   output reg        highpass_bypass_r,
   output reg        check_start_r,
   output reg        check_complete_flag_r,
   output reg        outside_clock_select_r,
   output reg        outside_trigger_select_r,
   output reg        settle_busy_r,
   output reg        sample_strobe_r,
   output reg        irq_r,
   input  wire       irq_pin_one_i,
   output reg        irq_pin_one_o_r,
   output reg        irq_pin_one_oe_r,
   input  wire       irq_pin_two_i,
   output reg        irq_pin_two_o_r,
   output reg        irq_pin_two_oe_r
);

   // soft reset pulse and combined synchronous reset
   reg                    soft_rst_r;
   wire                   rst_all;

   // interrupt status and mask
   reg [`ACP_IRQ_W-1:0]   irq_stat_r;
   reg [`ACP_IRQ_W-1:0]   irq_mask_r;
   reg [`ACP_IRQ_W-1:0]   irq_stat_nxt;

   // pin synchronisers and edge history
   reg                    pin1_s1_r;
   reg                    pin1_s2_r;
   reg                    pin1_d_r;
   reg                    pin2_s1_r;
   reg                    pin2_s2_r;
   reg                    pin2_d_r;

   // internal sample rate divider
   reg [26:0]             odr_cnt_r;
   reg                    int_tick_r;

   // decoded writes and reads
   wire                   wr_pwr;
   wire                   wr_check;
   wire                   wr_srst;
   wire                   wr_timing;
   wire                   wr_mask;
   wire                   rd_status;
   wire                   key_hit;

   // sample timing
   wire                   outside_clock_select_rise;
   wire                   ext_trig_rise;
   wire                   base_tick;
   wire                   sample_tick;

   // timers
   wire                   settle_load;
   wire [26:0]            settle_len;
   wire                   settle_step;
   wire                   settle_busy;
   wire                   settle_done;
   wire                   check_go;
   wire                   check_stop;
   wire                   check_clr;
   wire                   check_busy;
   wire                   check_done;
   wire [1:0]             new_mode;

   // register port decode; strobes are single cycles from the host
   assign wr_pwr    = reg_wr && (reg_addr == `ACP_ADDR_PWR);
   assign wr_check  = reg_wr && (reg_addr == `ACP_ADDR_CHECK);
   assign wr_srst   = reg_wr && (reg_addr == `ACP_ADDR_SRST);
   assign wr_timing = reg_wr && (reg_addr == `ACP_ADDR_TIMING);
   assign wr_mask   = reg_wr && (reg_addr == `ACP_ADDR_MASK);
   assign rd_status = reg_rd && (reg_addr == `ACP_ADDR_STATUS);

   // only the exact key counts; other values are dropped silently
   assign key_hit = wr_srst && (reg_wdata == `ACP_SRST_KEY);

   // the key write is turned into a one-cycle pulse that clears everything
   // the host is expected to be in standby first; not enforced here
   assign rst_all = !rst_b || soft_rst_r;

   always @(posedge ref_clk) begin
      if (!rst_b) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= key_hit;
      end
   end

   // power control register, bit 6 held at zero
   assign new_mode = reg_wdata[`ACP_PWR_MODE_HI:`ACP_PWR_MODE_LO];

   always @(posedge ref_clk) begin
      if (rst_all) begin
         mode_r                     <= `ACP_MODE_STANDBY;
         fast_bus_speed_select_r    <= 1'b0;
         impact_wake_level_select_r <= 1'b0;
         settling_period_select_r   <= 1'b0;
         lowpass_bypass_r           <= 1'b0;
         highpass_bypass_r          <= 1'b0;
      end else if (wr_pwr) begin
         mode_r                     <= new_mode;
         fast_bus_speed_select_r    <= reg_wdata[`ACP_PWR_FAST];
         impact_wake_level_select_r <= reg_wdata[`ACP_PWR_IMPACT];
         settling_period_select_r   <= reg_wdata[`ACP_PWR_SETTLE];
         lowpass_bypass_r           <= reg_wdata[`ACP_PWR_LPF];
         highpass_bypass_r          <= reg_wdata[`ACP_PWR_HPF];
      end
   end

   // timing register: selects the sample source on the two irq pins
   always @(posedge ref_clk) begin
      if (rst_all) begin
         outside_clock_select_r   <= 1'b0;
         outside_trigger_select_r <= 1'b0;
      end else if (wr_timing) begin
         outside_clock_select_r   <= reg_wdata[`ACP_TIM_CLK];
         outside_trigger_select_r <= reg_wdata[`ACP_TIM_TRIG];
      end
   end

   // two-flop synchronisers; edges are taken only past the second flop
   always @(posedge ref_clk) begin
      if (rst_all) begin
         pin1_s1_r <= 1'b0;
         pin1_s2_r <= 1'b0;
         pin1_d_r  <= 1'b0;
         pin2_s1_r <= 1'b0;
         pin2_s2_r <= 1'b0;
         pin2_d_r  <= 1'b0;
      end else begin
         pin1_s1_r <= irq_pin_one_i;
         pin1_s2_r <= pin1_s1_r;
         pin1_d_r  <= pin1_s2_r;
         pin2_s1_r <= irq_pin_two_i;
         pin2_s2_r <= pin2_s1_r;
         pin2_d_r  <= pin2_s2_r;
      end
   end

   // pins are inputs only while selected, so a stale drive is no edge
   assign outside_clock_select_rise  = outside_clock_select_r && pin1_s2_r && !pin1_d_r;
   assign ext_trig_rise = outside_trigger_select_r && pin2_s2_r && !pin2_d_r;

   // internal divider is held idle while an outside clock is chosen
   always @(posedge ref_clk) begin
      if (rst_all || outside_clock_select_r) begin
         odr_cnt_r  <= `ACP_ZERO27;
         int_tick_r <= 1'b0;
      end else if (odr_cnt_r >= ODR_CYC - `ACP_ONE27) begin
         odr_cnt_r  <= `ACP_ZERO27;
         int_tick_r <= 1'b1;
      end else begin
         odr_cnt_r  <= odr_cnt_r + `ACP_ONE27;
         int_tick_r <= 1'b0;
      end
   end

   // outside clock replaces the divider as the whole time base
   assign base_tick   = outside_clock_select_r ? outside_clock_select_rise : int_tick_r;
   // with a trigger chosen, each trigger edge is one sample and nothing else
   assign sample_tick = outside_trigger_select_r ? ext_trig_rise : base_tick;

   // sample strobe to the datapath; standby produces nothing
   always @(posedge ref_clk) begin
      if (rst_all) begin
         sample_strobe_r <= 1'b0;
      end else begin
         sample_strobe_r <= sample_tick && (mode_r != `ACP_MODE_STANDBY);
      end
   end

   // settling starts whenever the part leaves standby
   assign settle_load = wr_pwr && (mode_r == `ACP_MODE_STANDBY) &&
                        (new_mode != `ACP_MODE_STANDBY);
   // the length is chosen by the value being written, not the old one
   assign settle_len  = reg_wdata[`ACP_PWR_SETTLE] ? `ACP_SETTLE_ODR_N : SETTLE_CYC;
   // long wait counts clock cycles, short one counts sample periods
   assign settle_step = settling_period_select_r ? base_tick : 1'b1;

   acp_timer #(
      .W        (`ACP_TMR_W)
   ) u_settle (
      .ref_clk  (ref_clk),
      .clr      (rst_all || (wr_pwr && (new_mode == `ACP_MODE_STANDBY))),
      .load     (settle_load),
      .load_val (settle_len),
      .step     (settle_step),
      .busy_r   (settle_busy),
      .done_r   (settle_done)
   );

   // diagnostic check: a 1 starts, a 0 aborts and clears completion
   assign check_go   = wr_check && reg_wdata[`ACP_CHECK_START] && !check_start_r;
   assign check_stop = wr_check && !reg_wdata[`ACP_CHECK_START];
   assign check_clr  = rst_all || check_stop;

   acp_timer #(
      .W        (`ACP_TMR_W)
   ) u_check (
      .ref_clk  (ref_clk),
      .clr      (check_clr),
      .load     (check_go),
      .load_val (CHECK_CYC),
      .step     (1'b1),
      .busy_r   (check_busy),
      .done_r   (check_done)
   );

   // start bit is writable; the read-only flag follows the timer, and a
   // completion that meets an aborting write still shows (set wins)
   always @(posedge ref_clk) begin
      if (check_clr) begin
         check_start_r <= 1'b0;
      end else if (wr_check) begin
         check_start_r <= reg_wdata[`ACP_CHECK_START];
      end
      if (rst_all) begin
         check_complete_flag_r <= 1'b0;
      end else if (check_done) begin
         check_complete_flag_r <= 1'b1;
      end else if (check_go || check_stop) begin
         check_complete_flag_r <= 1'b0;
      end
   end

   // settle busy mirror for the datapath
   always @(posedge ref_clk) begin
      if (rst_all) begin
         settle_busy_r <= 1'b0;
      end else begin
         settle_busy_r <= settle_busy;
      end
   end

   // sticky status: a read clears, but an event in the same cycle survives
   always @* begin
      irq_stat_nxt = irq_stat_r;
      if (rd_status) begin
         irq_stat_nxt = `ACP_IRQ_RST;
      end
      if (settle_done) begin
         irq_stat_nxt[`ACP_IRQ_SETTLED] = 1'b1;
      end
      if (check_done) begin
         irq_stat_nxt[`ACP_IRQ_CHECKED] = 1'b1;
      end
      if (sample_strobe_r) begin
         irq_stat_nxt[`ACP_IRQ_SAMPLE] = 1'b1;
      end
   end

   always @(posedge ref_clk) begin
      if (rst_all) begin
         irq_stat_r <= `ACP_IRQ_RST;
         irq_mask_r <= `ACP_IRQ_RST;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         if (wr_mask) begin
            irq_mask_r <= reg_wdata[`ACP_IRQ_W-1:0];
         end
      end
   end

   // interrupt level and pin drive; a pin taken as input is released
   always @(posedge ref_clk) begin
      if (rst_all) begin
         irq_r            <= 1'b0;
         irq_pin_one_o_r  <= 1'b0;
         irq_pin_one_oe_r <= 1'b0;
         irq_pin_two_o_r  <= 1'b0;
         irq_pin_two_oe_r <= 1'b0;
      end else begin
         irq_r            <= |(irq_stat_r & irq_mask_r);
         irq_pin_one_o_r  <= |(irq_stat_r & irq_mask_r);
         irq_pin_one_oe_r <= !outside_clock_select_r;
         irq_pin_two_o_r  <= |(irq_stat_r & irq_mask_r);
         irq_pin_two_oe_r <= !outside_trigger_select_r;
      end
   end

   // read mux, answered one cycle after the strobe; unmapped reads give zero
   always @(posedge ref_clk) begin
      if (rst_all) begin
         reg_rdata <= `ACP_ZERO8;
      end else if (reg_rd) begin
         case (reg_addr)
            `ACP_ADDR_PWR: begin
               reg_rdata <= {fast_bus_speed_select_r, 1'b0,
                             impact_wake_level_select_r,
                             settling_period_select_r, lowpass_bypass_r,
                             highpass_bypass_r, mode_r};
            end
            `ACP_ADDR_CHECK: begin
               reg_rdata <= {6'h00, check_complete_flag_r, check_start_r};
            end
            `ACP_ADDR_TIMING: begin
               reg_rdata <= {6'h00, outside_trigger_select_r,
                             outside_clock_select_r};
            end
            `ACP_ADDR_STATUS: begin
               reg_rdata <= {5'h00, irq_stat_r};
            end
            `ACP_ADDR_MASK: begin
               reg_rdata <= {5'h00, irq_mask_r};
            end
            // the key register is write-only and reads as zero
            default: begin
               reg_rdata <= `ACP_ZERO8;
            end
         endcase
      end else begin
         reg_rdata <= `ACP_ZERO8;
      end
   end

endmodule

// ### verif/acp_host.sv
// acp_host.sv: host model driving the register port of the control bank.
// assumes the bank answers a read in the cycle after the strobe.
`timescale 1ns/1ps
module acp_host (
   input  logic       ref_clk,
   input  logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic       reg_wr,
   output logic       reg_rd
);
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // one-cycle write; released data lines flip so stale data is never reused
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      #1;
   endtask

   // read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // standby first, then the key; two edges for the reset to land
   task automatic soft_reset(input logic [7:0] pwr);
      wr(8'h3f, pwr & 8'hfc);
      wr(8'h41, 8'h52);
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
endmodule

// ### verif/acp_ctrl_asserts.sv
// acp_ctrl_asserts.sv: port-level checker of the power and mode control bank.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module acp_ctrl_chk (
   input logic       ref_clk,
   input logic       rst_b,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic       reg_wr,
   input logic       reg_rd,
   input logic [7:0] reg_rdata,
   input logic [1:0] mode_r,
   input logic       fast_bus_speed_select_r,
   input logic       impact_wake_level_select_r,
   input logic       settling_period_select_r,
   input logic       lowpass_bypass_r,
   input logic       highpass_bypass_r,
   input logic       check_start_r,
   input logic       check_complete_flag_r,
   input logic       outside_clock_select_r,
   input logic       outside_trigger_select_r,
   input logic       sample_strobe_r,
   input logic       irq_r,
   input logic       irq_pin_one_oe_r,
   input logic       irq_pin_two_oe_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   wire       pwr_wr    = reg_wr && reg_addr == 8'h3f;
   wire       key_wr    = reg_wr && reg_addr == 8'h41;
   wire       key_ok    = key_wr && reg_wdata == 8'h52;
   wire       chk_wr    = reg_wr && reg_addr == 8'h40;
   wire       pwr_rd    = reg_rd && reg_addr == 8'h3f;
   wire       chk_rd    = reg_rd && reg_addr == 8'h40;
   wire       clk_sel   = outside_clock_select_r;
   wire       trig_sel  = outside_trigger_select_r;
   wire [4:0] fld_bits  = {fast_bus_speed_select_r, impact_wake_level_select_r,
                           settling_period_select_r, lowpass_bypass_r, highpass_bypass_r};
   wire [4:0] wr_bits   = {reg_wdata[7], reg_wdata[5:2]};
   wire [7:0] pwr_view  = {fld_bits[4], 1'b0, fld_bits[3:0], mode_r};
   wire [7:0] chk_view  = {6'h00, check_complete_flag_r, check_start_r};
   wire       bank_idle = mode_r == 2'h0 && !check_start_r && !clk_sel && !trig_sel;

   // a completion that meets an aborting write may still raise the flag
   property start_write_p;
      chk_wr |=> check_start_r == $past(reg_wdata[0]) && ($past(reg_wdata[0])
         || !check_complete_flag_r || $rose(check_complete_flag_r));
   endproperty

   // write and read paths of the control fields
   chk_mode_write: assert property (pwr_wr |=> mode_r == $past(reg_wdata[1:0]))
      else $error("mode field not taken from write");
   chk_bits_write: assert property (pwr_wr |=> fld_bits == $past(wr_bits))
      else $error("power control bits not taken from write");
   chk_pwr_read: assert property (pwr_rd |=> reg_rdata == $past(pwr_view))
      else $error("power control read wrong");
   chk_check_read: assert property (chk_rd |=> reg_rdata == $past(chk_view))
      else $error("check register read wrong");
   chk_start_write: assert property (start_write_p)
      else $error("check start or flag wrong after write");
   chk_key_read: assert property (reg_rd && reg_addr == 8'h41 |=> reg_rdata == 8'h00)
      else $error("key register not write-only");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   // soft reset by key only
   chk_key_reset: assert property (key_ok |-> ##2 bank_idle)
      else $error("key did not reset the bank");
   chk_wrong_key: assert property (key_wr && !key_ok |=> ##1 $stable(mode_r))
      else $error("wrong key disturbed the bank");
   // pins turn to inputs
   chk_pin_one_in: assert property (clk_sel && $past(clk_sel) |-> !irq_pin_one_oe_r)
      else $error("pin one driven while clock input");
   chk_pin_two_in: assert property (trig_sel && $past(trig_sel) |-> !irq_pin_two_oe_r)
      else $error("pin two driven while trigger input");

   cov_key: cover property (key_wr && reg_wdata == 8'h52);
   cov_flag: cover property ($rose(check_complete_flag_r));
   cov_irq: cover property ($rose(irq_r));
   cov_trig: cover property (outside_trigger_select_r && sample_strobe_r);
endmodule

bind acp_ctrl acp_ctrl_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mode_r(mode_r), .fast_bus_speed_select_r(fast_bus_speed_select_r),
   .impact_wake_level_select_r(impact_wake_level_select_r),
   .settling_period_select_r(settling_period_select_r), .lowpass_bypass_r(lowpass_bypass_r),
   .highpass_bypass_r(highpass_bypass_r), .check_start_r(check_start_r),
   .check_complete_flag_r(check_complete_flag_r), .outside_clock_select_r(outside_clock_select_r),
   .outside_trigger_select_r(outside_trigger_select_r), .sample_strobe_r(sample_strobe_r),
   .irq_r(irq_r), .irq_pin_one_oe_r(irq_pin_one_oe_r), .irq_pin_two_oe_r(irq_pin_two_oe_r));

// ### verif/acp_ctrl_bench.sv
// acp_ctrl_bench.sv: self-checking bench of the power and mode control bank.
// assumes short timer parameters; the board side of both irq pins is driven here.
`timescale 1ns/1ps
module acp_ctrl_bench;
   logic       ref_clk, rst_b, ext_one, ext_two, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic [1:0] mode_r;
   logic       fast_r, impact_r, settle_r, lpf_r, hpf_r, start_r, flag_r;
   logic       clk_sel_r, trig_sel_r, busy_r, strobe_r, irq_r;
   logic       one_o, one_oe, two_o, two_oe;
   wire        pin_one = one_oe ? one_o : ext_one;
   wire        pin_two = two_oe ? two_o : ext_two;
   wire  [7:0] pwr_seen = {fast_r, 1'b0, impact_r, settle_r, lpf_r, hpf_r, mode_r};
   int         num_errors, checked, m_pwr, i, n;
   logic [7:0] reg_q [$] = '{8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44};

   acp_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

   acp_ctrl #(.SETTLE_CYC(27'h0000032), .ODR_CYC(27'h0000008), .CHECK_CYC(27'h0000014)) DUT (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_r(mode_r),
      .fast_bus_speed_select_r(fast_r), .impact_wake_level_select_r(impact_r),
      .settling_period_select_r(settle_r), .lowpass_bypass_r(lpf_r),
      .highpass_bypass_r(hpf_r), .check_start_r(start_r), .check_complete_flag_r(flag_r),
      .outside_clock_select_r(clk_sel_r), .outside_trigger_select_r(trig_sel_r),
      .settle_busy_r(busy_r), .sample_strobe_r(strobe_r), .irq_r(irq_r),
      .irq_pin_one_i(pin_one), .irq_pin_one_o_r(one_o), .irq_pin_one_oe_r(one_oe),
      .irq_pin_two_i(pin_two), .irq_pin_two_o_r(two_o), .irq_pin_two_oe_r(two_oe));

   task automatic cmp(string what, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // bounded waits; a one-cycle strobe is looked at in every cycle
   task automatic wait_strobe(string what);
      for (int k = 0; k < 12 && strobe_r !== 1'b1; k++) begin
         @(posedge ref_clk);
         #1;
      end
      cmp(what, {7'h00, strobe_r}, 8'h01);
   endtask

   task automatic wait_flag;
      for (int k = 0; k < 60 && flag_r !== 1'b1; k++) begin
         @(posedge ref_clk);
         #1;
      end
      cmp("check flag", {7'h00, flag_r}, 8'h01);
   endtask

   task automatic read_all_zero(string what);
      foreach (reg_q[k]) begin
         host.rd(reg_q[k], v);
         cmp(what, v, 8'h00);
      end
   endtask

   // standby, then leave it with pwr; settling busy cycles must lie in lo..hi
   task automatic settle_run(logic [7:0] pwr, logic [7:0] lo, logic [7:0] hi);
      host.wr(8'h3f, 8'h00);
      host.wr(8'h3f, pwr);
      n = 0;
      for (int k = 0; k < 100; k++) begin
         @(posedge ref_clk);
         #1;
         n += (busy_r === 1'b1);
      end
      cmp("settle cycles", {7'h00, n[7:0] >= lo && n[7:0] <= hi}, 8'h01);
      host.rd(8'h43, v);
      cmp("settled status", v & 8'h01, 8'h01);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // watchdog at 20000 cycles, well past the few hundred cycles the tests need
   initial begin
      #100000;
      num_errors++;
      conclude();
   end

   initial begin
      rst_b = 1'b0;
      ext_one = 1'b0;
      ext_two = 1'b0;
      void'($urandom(32'hc6a73608));
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      read_all_zero("reset value");
      $display("test reset done");
      // long wait is 50 clock cycles, short one four 8-cycle sample periods
      settle_run(8'h01, 8'h32, 8'h32);
      settle_run(8'h11, 8'h19, 8'h20);
      $display("test settle done");
      // every mode, random upper bits, reserved bit 6 forced high
      for (i = 0; i < 4; i++) begin
         v = ($urandom & 8'hfc) | 8'h40 | i;
         host.wr(8'h3f, v);
         m_pwr = v & 8'hbf;
         cmp("power fields", pwr_seen, m_pwr[7:0]);
         host.rd(8'h3f, v);
         cmp("power read", v, m_pwr[7:0]);
      end
      $display("test power done");
      // check with interrupt masked, then unmasked, then cleared by status read
      host.wr(8'h44, 8'h00);
      host.wr(8'h40, 8'hff);
      wait_flag();
      cmp("irq masked", {7'h00, irq_r}, 8'h00);
      host.rd(8'h40, v);
      cmp("check read", v, 8'h03);
      host.rd(8'h43, v);
      cmp("status check", v & 8'h02, 8'h02);
      host.wr(8'h44, 8'h02);
      host.wr(8'h40, 8'h00);
      cmp("flag cleared", {6'h00, flag_r, start_r}, 8'h00);
      host.wr(8'h40, 8'h01);
      wait_flag();
      repeat (2) @(posedge ref_clk);
      #1;
      cmp("irq raised", {5'h00, irq_r, one_o, two_o}, 8'h07);
      host.rd(8'h43, v);
      repeat (2) @(posedge ref_clk);
      #1;
      cmp("irq cleared", {5'h00, irq_r, one_o, two_o}, 8'h00);
      $display("test check done");
      // outside clock: no samples without edges on pin one, then a sample after an edge
      host.wr(8'h42, 8'h01);
      repeat (4) @(posedge ref_clk);
      n = 0;
      for (i = 0; i < 40; i++) begin
         @(posedge ref_clk);
         #1;
         n += (strobe_r === 1'b1);
      end
      cmp("free samples", n[7:0], 8'h00);
      cmp("pin one oe", {7'h00, one_oe}, 8'h00);
      @(posedge ref_clk) ext_one <= 1'b1;
      wait_strobe("clock sample");
      @(posedge ref_clk) ext_one <= 1'b0;
      // outside trigger on pin two
      host.wr(8'h42, 8'h02);
      repeat (4) @(posedge ref_clk);
      cmp("pin two oe", {7'h00, two_oe}, 8'h00);
      @(posedge ref_clk) ext_two <= 1'b1;
      wait_strobe("trigger sample");
      @(posedge ref_clk) ext_two <= 1'b0;
      $display("test pins done");
      // wrong key ignored, right key restores every register
      host.wr(8'h41, 8'h51);
      host.rd(8'h3f, v);
      cmp("wrong key", v, m_pwr[7:0]);
      host.soft_reset(m_pwr[7:0]);
      m_pwr = 0;
      read_all_zero("after key");
      cmp("mode after key", pwr_seen, m_pwr[7:0]);
      $display("test soft reset done");
      conclude();
   end
endmodule
